// *** design/gpev_pkg.sv ***
// Purpose : Constants for the general-purpose port block with edge events
// Assumes : 8-bit register port, 125 MHz system clock
// Notes   : Overview of operation follows
////////////////////////////////////////////////////////////////////////////////
package gpev_pkg;

  // Register offsets, ports two, three, four in index order 0..2
  localparam logic [2:0][7:0] DIR_OFF = {8'hf4, 8'hf0, 8'he3};
  localparam logic [2:0][7:0] DAT_OFF = {8'hf5, 8'hf1, 8'he4};
  localparam logic [2:0][7:0] INV_OFF = {8'hf6, 8'hf2, 8'he5};
  // Event status, ports two..five in index order 0..3
  localparam logic [3:0][7:0] EV_OFF  = {8'he9, 8'he8, 8'he7, 8'he6};
  localparam logic [7:0] ACT_OFF = 8'h30;
  localparam logic [7:0] LED_OFF = 8'hf3;
  localparam logic [7:0] ALT_OFF = 8'hf7;

  // Field positions
  localparam int LED_MODE_HI = 7;
  localparam int LED_MODE_LO = 6;

  // Reset values
  localparam logic [7:0] DIR_RST  = 8'hff;
  localparam logic [7:0] DAT_RST  = 8'h00;
  localparam logic [7:0] INV_RST  = 8'h00;
  localparam logic [7:0] EV_RST   = 8'h00;
  localparam logic [7:0] ALT_RST  = 8'h00;
  localparam logic [3:0] ACT_RST  = 4'h0;
  localparam logic [1:0] LED_RST  = 2'h0;

  // Indicator mode codes
  localparam logic [1:0] LED_TRI   = 2'h0;
  localparam logic [1:0] LED_LOW   = 2'h1;
  localparam logic [1:0] LED_FAST  = 2'h2;
  localparam logic [1:0] LED_SLOW  = 2'h3;

  // Timing: blink half period of the 1 Hz mode
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

endpackage

// *** design/gpev_top.sv ***
// Purpose : Three I/O ports, four event ports, indicator LED, alt select
// Assumes : Pins synchronous-capable, single clock, synchronous resets
// Notes   : vbat_resetn only clears the indicator mode setting
////////////////////////////////////////////////////////////////////////////////
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module gpev_top #(
  parameter int unsigned HALF_CYC = gpev_pkg::BLINK_HALF_CYC
) (
  // Clock and resets
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       vbat_resetn,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Port two pins
  input  wire logic [7:0] port_two_pins_in,
  output logic      [7:0] port_two_pins_out,
  output logic      [7:0] port_two_pins_oe,
  // Port three pins
  input  wire logic [7:0] port_three_pins_in,
  output logic      [7:0] port_three_pins_out,
  output logic      [7:0] port_three_pins_oe,
  // Port four pins
  input  wire logic [7:0] port_four_pins_in,
  output logic      [7:0] port_four_pins_out,
  output logic      [7:0] port_four_pins_oe,
  // Port five pins, event sensing only
  input  wire logic [7:0] port_five_pins_in,
  // Watchdog expiry from the watchdog, active low
  input  wire logic       watchdog_expiry_out_n,
  // Indicator LED pin
  output logic            sleep_indicator_out,
  output logic            sleep_indicator_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0]      act;
    logic [2:0][7:0] dir;
    logic [2:0][7:0] dat;
    logic [2:0][7:0] inv;
    logic [7:0]      alt;
    logic [1:0]      led_mode;
    logic [3:0][7:0] s1;
    logic [3:0][7:0] s2;
    logic [3:0][7:0] s3;
    logic [3:0][7:0] ev;
    logic [25:0]     pre;
    logic [2:0]      half;
    logic [7:0]      rdata;
  } gpev_state_t;

  gpev_state_t     st_r;
  gpev_state_t     st_nxt;
  logic [3:0][7:0] pin_in;
  logic [3:0][7:0] edg;
  logic [2:0][7:0] gp_out;
  logic [2:0][7:0] gp_oe;
  logic            tick;
  logic            blink;

  // Read view of a data register: pin level xor inversion for inputs, latch for outputs
  function automatic logic [7:0] gpev_rd_data(input logic [7:0] dir,
                                              input logic [7:0] dat,
                                              input logic [7:0] inv,
                                              input logic [7:0] pin);
    gpev_rd_data = (dir & (pin ^ inv)) | (~dir & dat);
  endfunction

  // Write merge: only output bits take the new value
  function automatic logic [7:0] gpev_wr_data(input logic [7:0] dir,
                                              input logic [7:0] old,
                                              input logic [7:0] wd);
    gpev_wr_data = (dir & old) | (~dir & wd);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin grouping and edge detection after two-stage synchroniser
  assign pin_in = {port_five_pins_in, port_four_pins_in,
                   port_three_pins_in, port_two_pins_in};

  // Edges seen on s2 against s3; s1 feeds nothing but s2
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      edg[i] = (st_r.s2[i] ^ st_r.s3[i]) & {8{st_r.act[i]}};
    end
  end

  // Half-second tick from the system clock
  assign tick = (st_r.pre == 26'(HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    // Synchroniser chain, one bit per pin
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Blink divider runs free so mode changes take effect at once
    st_nxt.pre = tick ? 26'h0 : st_r.pre + 26'h1;
    if (tick) begin
      st_nxt.half = st_r.half + 3'h1;
    end
    // Register writes
    if (wr) begin
      for (int k = 0; k < 3; k++) begin
        if (addr == gpev_pkg::DIR_OFF[k]) begin
          st_nxt.dir[k] = wdata;
        end
        if (addr == gpev_pkg::DAT_OFF[k]) begin
          st_nxt.dat[k] = gpev_wr_data(st_r.dir[k], st_r.dat[k], wdata);
        end
        if (addr == gpev_pkg::INV_OFF[k]) begin
          st_nxt.inv[k] = wdata;
        end
      end
      if (addr == gpev_pkg::ACT_OFF) begin
        st_nxt.act = wdata[3:0];
      end
      if (addr == gpev_pkg::ALT_OFF) begin
        st_nxt.alt = wdata;
      end
      if (addr == gpev_pkg::LED_OFF) begin
        st_nxt.led_mode = wdata[gpev_pkg::LED_MODE_HI:gpev_pkg::LED_MODE_LO];
      end
    end
    // Events: a new edge wins over the clear by the same read
    for (int i = 0; i < 4; i++) begin
      if (rd && addr == gpev_pkg::EV_OFF[i]) begin
        st_nxt.ev[i] = edg[i];
      end else begin
        st_nxt.ev[i] = st_r.ev[i] | edg[i];
      end
    end
    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 8'h00;
    if (rd) begin
      for (int k = 0; k < 3; k++) begin
        if (addr == gpev_pkg::DIR_OFF[k]) begin
          st_nxt.rdata = st_r.dir[k];
        end
        if (addr == gpev_pkg::DAT_OFF[k]) begin
          st_nxt.rdata = gpev_rd_data(st_r.dir[k], st_r.dat[k],
                                      st_r.inv[k], st_r.s2[k]);
        end
        if (addr == gpev_pkg::INV_OFF[k]) begin
          st_nxt.rdata = st_r.inv[k];
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (addr == gpev_pkg::EV_OFF[i]) begin
          st_nxt.rdata = st_r.ev[i];
        end
      end
      if (addr == gpev_pkg::ACT_OFF) begin
        st_nxt.rdata = {4'h0, st_r.act};
      end
      if (addr == gpev_pkg::ALT_OFF) begin
        st_nxt.rdata = st_r.alt;
      end
      if (addr == gpev_pkg::LED_OFF) begin
        st_nxt.rdata = {st_r.led_mode, 6'h00};
      end
    end
    // Indicator mode sits on the battery reset and survives main reset
    if (!vbat_resetn) begin
      st_nxt.led_mode = gpev_pkg::LED_RST;
    end
    // Main reset: everything but the indicator mode
    if (!resetn) begin
      st_nxt.act   = gpev_pkg::ACT_RST;
      st_nxt.dir   = {3{gpev_pkg::DIR_RST}};
      st_nxt.dat   = {3{gpev_pkg::DAT_RST}};
      st_nxt.inv   = {3{gpev_pkg::INV_RST}};
      st_nxt.alt   = gpev_pkg::ALT_RST;
      st_nxt.s1    = '0;
      st_nxt.s2    = '0;
      st_nxt.s3    = '0;
      st_nxt.ev    = {4{gpev_pkg::EV_RST}};
      st_nxt.pre   = 26'h0;
      st_nxt.half  = 3'h0;
      st_nxt.rdata = 8'h00;
    end
  end

  // State register; both resets are folded into the next-state logic
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator: fast mode toggles each half second, slow mode each two
  assign blink = st_r.led_mode[0] ? st_r.half[2] : st_r.half[0];
  assign sleep_indicator_oe  = (st_r.led_mode != gpev_pkg::LED_TRI);
  assign sleep_indicator_out = st_r.led_mode[1] & blink;

  // General-purpose drive; an inactive port releases all its general-purpose pins
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      gp_out[k] = st_r.dat[k] ^ st_r.inv[k];
      gp_oe[k]  = ~st_r.dir[k] & {8{st_r.act[k]}};
    end
  end

  assign port_two_pins_out   = gp_out[0];
  assign port_two_pins_oe    = gp_oe[0];
  assign port_three_pins_out = gp_out[1];
  assign port_three_pins_oe  = gp_oe[1];

  // Port four alternate routing overrides direction and activation
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!st_r.alt[b]) begin
        port_four_pins_out[b] = gp_out[2][b];
        port_four_pins_oe[b]  = gp_oe[2][b];
      end else if (b % 2 == 1) begin
        port_four_pins_out[b] = sleep_indicator_out;
        port_four_pins_oe[b]  = sleep_indicator_oe;
      end else begin
        port_four_pins_out[b] = watchdog_expiry_out_n;
        port_four_pins_oe[b]  = 1'b1;
      end
    end
  end

  assign rdata = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  dir_reset_a: assert property (@(posedge clk)
    !resetn |=> st_r.dir == {3{8'hff}} && st_r.ev == '0)
    else $error("direction or events not reset");


  // Data writes: output bits follow the write, input bits hold their value
  out_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == gpev_pkg::DAT_OFF[0]
    |=> ((st_r.dat[0] ^ $past(wdata)) & ~$past(st_r.dir[0])) == 8'h00)
    else $error("output data write lost");

  in_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr && addr == gpev_pkg::DAT_OFF[0]
    |=> ((st_r.dat[0] ^ $past(st_r.dat[0])) & $past(st_r.dir[0])) == 8'h00)
    else $error("input data bits changed by write");

  // Pin drive follows direction and inversion on an active port
  dir_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.act[0]
    |-> port_two_pins_oe == ~st_r.dir[0])
    else $error("port two drive enable wrong");

  pin_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    1'b1
    |-> port_two_pins_out == (st_r.dat[0] ^ st_r.inv[0]))
    else $error("port two drive level wrong");

  in_read_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == 8'hf1 && st_r.dir[1] == 8'hff
    |=> rdata == ($past(st_r.s2[1]) ^ $past(st_r.inv[1])))
    else $error("input read not pin xor inversion");

  edge_set_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.act[0] && $rose(port_two_pins_in[3])
    |-> ##3 st_r.ev[0][3])
    else $error("edge did not set event flag");

  read_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    rd && addr == 8'he7
    |=> rdata == $past(st_r.ev[1]) && st_r.ev[1] == $past(edg[1]))
    else $error("read-clear wrong");

  led_low_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.led_mode == 2'h1 |-> sleep_indicator_oe && !sleep_indicator_out)
    else $error("indicator not driven low");

  led_blink_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.led_mode == 2'h2 && $past(st_r.led_mode) == 2'h2 && $past(tick)
    |-> sleep_indicator_out != $past(sleep_indicator_out))
    else $error("fast blink did not toggle");

  led_keep_a: assert property (@(posedge clk)
    !resetn && vbat_resetn && !wr |=> $stable(st_r.led_mode))
    else $error("indicator mode lost on main reset");

  alt_route_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.alt[6] |-> port_four_pins_out[6] == watchdog_expiry_out_n
                 && port_four_pins_oe[6])
    else $error("watchdog not routed to pin six");


  // An inactive port neither drives its general-purpose pins nor records edges
  idle_port_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.act[1]
    |-> port_three_pins_oe == 8'h00)
    else $error("inactive port still drives");

  idle_event_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_r.act[1] && !(rd && addr == gpev_pkg::EV_OFF[1])
    |=> st_r.ev[1] == $past(st_r.ev[1]))
    else $error("inactive port recorded an edge");

  // Flags only drop through a read of their own register
  ev_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
    !(rd && addr == gpev_pkg::EV_OFF[0])
    |=> (st_r.ev[0] & $past(st_r.ev[0])) == $past(st_r.ev[0]))
    else $error("event flag dropped without a read");

  // Port five has no drive, only edge sensing on its own bit positions
  edge_five_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.act[3] && $rose(port_five_pins_in[7])
    |-> ##3 st_r.ev[3][7])
    else $error("port five edge not recorded on bit seven");

  // Indicator: tri-state at code 00, slow blink turns every fourth tick
  led_tri_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.led_mode == 2'h0
    |-> !sleep_indicator_oe)
    else $error("indicator driven in tri-state mode");

  slow_blink_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.led_mode == 2'h3 && $past(st_r.led_mode) == 2'h3 && $past(tick)
    && $past(st_r.half[1:0]) == 2'h3
    |-> sleep_indicator_out != $past(sleep_indicator_out))
    else $error("slow blink did not toggle");

  // Battery reset alone clears the indicator mode
  vbat_clear_a: assert property (@(posedge clk)
    !vbat_resetn
    |=> st_r.led_mode == 2'h0)
    else $error("indicator mode not cleared by battery reset");

  // Odd alternate pins carry the indicator, enable included
  alt_led_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.alt[1]
    |-> port_four_pins_out[1] == sleep_indicator_out
        && port_four_pins_oe[1] == sleep_indicator_oe)
    else $error("indicator not routed to pin one");

  // Main reset leaves every port inactive and clears data and inversion
  act_reset_a: assert property (@(posedge clk)
    !resetn
    |=> st_r.act == 4'h0 && port_two_pins_oe == 8'h00)
    else $error("ports active after reset");

  data_reset_a: assert property (@(posedge clk)
    !resetn
    |=> st_r.dat == '0 && st_r.inv == '0)
    else $error("data or inversion not reset");

endmodule

`default_nettype wire

// *** dv/gpev_board.sv ***
// Purpose : Board side of one eight-bit port
// Assumes : No pull on the pins; the bench sets the undriven level
// Notes   : A pin the device drives reads back the driven level
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none

module gpev_board (
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board side
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  // Driven pins echo the device, the rest follow the board
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

`default_nettype wire

// *** dv/gpio_ports_event_status_test.sv ***
// Purpose : Self-checking bench for the port block with edge events
// Assumes : Blink half period shortened to 8 cycles
// Notes   : Table covers reset values, hand tests cover the rest
////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none

module gpio_ports_event_status_test;
  logic             clk, resetn, vbat_resetn, wr, rd, wd_n, led, led_oe;
  logic [7:0]       addr, wdata, rdata, v, v2;
  logic [3:0][7:0]  ext;
  wire  [3:0][7:0]  pin, o, oe;
  int               n_errors = 0;
  int               check_count = 0;
  // Address beside expected value after reset; 55 is unmapped
  logic [15:0]      rows [17] = '{16'he3ff, 16'hf0ff, 16'hf4ff,
    16'he400, 16'hf100, 16'hf500, 16'he500, 16'hf200, 16'hf600,
    16'he600, 16'he700, 16'he800, 16'he900, 16'hf300, 16'hf700,
    16'h3000, 16'h5500};

  gpev_top #(.HALF_CYC(8)) dut (.clk(clk), .resetn(resetn),
    .vbat_resetn(vbat_resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .port_two_pins_in(pin[0]),
    .port_two_pins_out(o[0]), .port_two_pins_oe(oe[0]),
    .port_three_pins_in(pin[1]), .port_three_pins_out(o[1]),
    .port_three_pins_oe(oe[1]), .port_four_pins_in(pin[2]),
    .port_four_pins_out(o[2]), .port_four_pins_oe(oe[2]),
    .port_five_pins_in(ext[3]), .watchdog_expiry_out_n(wd_n),
    .sleep_indicator_out(led), .sleep_indicator_oe(led_oe));

  // Board model for each port with outputs; port five is sensed only
  for (genvar g = 0; g < 3; g++) begin : g_brd
    gpev_board b (.pin_out(o[g]), .pin_oe(oe[g]), .ext(ext[g]),
      .pin_in(pin[g]));
  end
  assign o[3] = 8'h00;
  assign oe[3] = 8'h00;
  assign pin[3] = ext[3];

  ////////////////////////////////////////////////////////////////////////
  // Clock and checking helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask

  // Cycles between two indicator toggles, bounded so a stuck pin fails
  task automatic period(input logic [7:0] exp);
    logic [7:0] n;
    logic       l;
    for (int k = 0; k < 2; k++) begin
      n = 8'h00;
      l = led;
      while (led === l && n < 8'h64) begin
        @(negedge clk);
        n++;
      end
    end
    check(n, exp);
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn, vbat_resetn, wr, rd, addr, wdata, ext} = '0;
    wd_n = 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    vbat_resetn <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      rd_chk(rows[i][15:8], rows[i][7:0]);
    end
    check({7'h00, led_oe}, 8'h00);
    wr_reg(8'h30, 8'h0f);
    rd_chk(8'h30, 8'h0f);
    // Port two: low nibble driven, high nibble read from the board
    ext[0] <= 8'h30;
    wr_reg(8'he3, 8'hf0);
    wr_reg(8'he4, 8'ha5);
    wr_reg(8'he5, 8'h0c);
    @(negedge clk);
    check(oe[0], 8'h0f);
    check(o[0] & 8'h0f, 8'h09);
    rd_chk(8'he4, 8'h35);
    wr_reg(8'he3, 8'h00);
    rd_chk(8'he4, 8'h05);
    wr_reg(8'he3, 8'hff);
    wr_reg(8'he5, 8'hff);
    rd_chk(8'he4, 8'hcf);
    wr_reg(8'he5, 8'h00);
    for (int p = 0; p < 4; p++) begin
      rd_reg(gpev_pkg::EV_OFF[p], v);
    end
    // One pin edge per port, each on a different bit position
    for (int p = 0; p < 4; p++) begin
      ext[p] <= ext[p] ^ (8'h02 << (2 * p));
      repeat (5) @(posedge clk);
      rd_chk(gpev_pkg::EV_OFF[p], 8'h02 << (2 * p));
      rd_chk(gpev_pkg::EV_OFF[p], 8'h00);
    end
    // Edge lands on the read-clear edge; it must show in the second of two reads
    ext[0] <= ext[0] ^ 8'h01;
    repeat (1) @(posedge clk);
    rd_reg(gpev_pkg::EV_OFF[0], v);
    rd_reg(gpev_pkg::EV_OFF[0], v2);
    check(v | v2, 8'h01);
    check(v2, 8'h01);
    // Port three inactive: no events, no drive
    wr_reg(8'h30, 8'h0d);
    ext[1] <= ext[1] ^ 8'h10;
    wr_reg(8'hf0, 8'h00);
    @(negedge clk);
    check(oe[1], 8'h00);
    rd_chk(8'he7, 8'h00);
    wr_reg(8'hf1, 8'h5a);
    @(negedge clk);
    check(o[1], 8'h5a);
    wr_reg(8'hf0, 8'hff);
    // Indicator low, routed to port four with the watchdog level
    wr_reg(8'hf3, 8'h40);
    wr_reg(8'hf7, 8'h43);
    @(negedge clk);
    check({6'h00, led_oe, led}, 8'h02);
    check(oe[2], 8'h43);
    check(o[2] & 8'h03, 8'h01);
    @(posedge clk);
    wd_n <= 1'b0;
    @(negedge clk);
    check(o[2] & 8'h43, 8'h00);
    // Port four general-purpose pins beside the alternate ones
    wr_reg(8'hf4, 8'h00);
    wr_reg(8'hf5, 8'h3c);
    wr_reg(8'hf6, 8'h80);
    @(negedge clk);
    check(o[2] & 8'hbc, 8'hbc);
    check(oe[2], 8'hff);
    rd_chk(8'hf5, 8'h3c);
    wr_reg(8'hf3, 8'h80);
    period(8'h08);
    wr_reg(8'hf3, 8'hc0);
    period(8'h20);
    // Main reset keeps the mode, battery reset clears it
    wr_reg(8'hf3, 8'h40);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(8'hf3, 8'h40);
    rd_chk(8'he3, 8'hff);
    @(posedge clk);
    vbat_resetn <= 1'b0;
    repeat (2) @(posedge clk);
    vbat_resetn <= 1'b1;
    rd_chk(8'hf3, 8'h00);
    stop_test;
  end
endmodule

`default_nettype wire
